// ---- hdl/crs_defs.svh ----
// Purpose: offsets, field positions and reset values of the cpu register state block
// Assumes: included by bare name from the design file; the package does not include it
// Notes: byte offsets on the register bus, one aligned 32-bit word each
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ****************************************************************
// register bus offsets
// ****************************************************************
`define CRS_OFF_GPR_BASE 8'h00
`define CRS_OFF_CODE_SEG 8'h20
`define CRS_OFF_DATA_SEG 8'h24
`define CRS_OFF_STACK_SEG 8'h28
`define CRS_OFF_EXTRA_SEG 8'h2C
`define CRS_OFF_PSW 8'h30
`define CRS_OFF_FETCH_ADDR 8'h34
`define CRS_OFF_LAST 8'h34

// ****************************************************************
// reset values
// ****************************************************************
`define CRS_RST_CODE_SEG 16'hFFFF
`define CRS_RST_SEG 16'h0000
`define CRS_RST_IOFF 16'h0000
`define CRS_RST_PSW 16'h0000
`define CRS_RST_FETCH 20'hFFFF0

// ****************************************************************
// status word fields
// ****************************************************************
`define CRS_PSW_MASK 16'h0FD5
`define CRS_BIT_OVERFLOW 11
`define CRS_BIT_DIRECTION 10
`define CRS_BIT_INT_EN 9
`define CRS_BIT_TRACE 8
`define CRS_BIT_SIGN 7
`define CRS_BIT_ZERO 6
`define CRS_BIT_AUX 4
`define CRS_BIT_PARITY 2
`define CRS_BIT_CARRY 0

// ****************************************************************
// general register indices and bus answers
// ****************************************************************
`define CRS_IDX_ACC 3'h0
`define CRS_IDX_COUNT 3'h1
`define CRS_IDX_DATA 3'h2
`define CRS_RESP_OKAY 2'h0
`define CRS_RESP_SLVERR 2'h2

`endif

// ---- hdl/crs_pkg.sv ----
// Purpose: types shared by the cpu register state block and its users
// Assumes: crs_defs.svh holds every number except the alu kind encodings below
// Notes: nothing here is imported; users write crs_pkg::name
package crs_pkg;

  typedef enum logic [1:0] {
    CRS_ALU_ADD = 2'b00,
    CRS_ALU_SUB = 2'b01,
    CRS_ALU_LOGIC = 2'b10
  } crs_alu_e;

  // general register write port from the execution datapath
  typedef struct packed {
    logic we;
    logic [2:0] sel;
    logic byte_sel;
    logic high;
    logic [15:0] data;
  } crs_gpr_wr_s;

  typedef struct packed {
    logic we;
    logic [1:0] sel;
    logic [15:0] data;
  } crs_seg_wr_s;

  // outcome of one executed arithmetic or logic instruction
  typedef struct packed {
    logic valid;
    crs_alu_e kind;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
  } crs_alu_upd_s;

  typedef struct packed {
    logic set_dir;
    logic clr_dir;
    logic set_int;
    logic clr_int;
    logic psw_load;
    logic [15:0] psw_data;
  } crs_flag_ctl_s;

  typedef struct packed {
    logic [7:0][15:0] gpr;
    logic [3:0][15:0] seg;
    logic [15:0] psw;
    logic [15:0] ioff;
    logic [19:0] phys_addr;
    logic [19:0] fetch_addr;
    logic trace_trap;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } crs_state_s;

endpackage : crs_pkg

// ---- hdl/crs_regs.sv ----
// Purpose: architectural register state, status flags and address forming
// Assumes: one clock, datapath inputs synchronous, axi4-lite master keeps its protocol
// Notes: datapath writes win over bus writes to the same register in one cycle
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "crs_defs.svh"

// Contract
// RQ1: eight 16-bit general registers; first four also reachable as byte halves.
// RQ2: four 16-bit segment bases for code, data, stack and extra data.
// RQ3: reset loads code segment base with FFFF; segments span 64K.
// RQ4: reset clears data, stack and extra segment bases to zero.
// RQ5: instruction offset is 16 bits, resets to zero; first fetch at FFFF0.
// RQ6: instruction offset is not software visible; only bus unit and flow change it.
// RQ7: status word updated per instruction, resets zero, reserved bits read zero.
// RQ8: overflow flag bit 11 set on signed arithmetic overflow.
// RQ9: direction flag bit 10 set steps strings upward; own set and clear.
// RQ10: interrupt enable bit 9 gates maskable requests; own set and clear.
// RQ11: trace bit 8 set by flag load traps after following instruction, then each.
// RQ12: sign flag bit 7 equals result most significant bit.
// RQ13: zero flag bit 6 set when result is zero.
// RQ14: aux carry bit 4 set on carry or borrow across low nibble.
// RQ15: parity flag bit 2 set when low result byte has even ones.
// RQ16: carry flag bit 0 set on carry out of or borrow into msb.
// RQ17: forms 20-bit physical address from 16-bit segment and offset.
// RQ18: count low byte gives shift count; full count word counts loops.
// RQ19: accumulator and data word pair for word multiply and divide; data gives port.
// RQ20: physical address is segment shifted left four plus offset, twenty bits.
module crs_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire crs_pkg::crs_gpr_wr_s gpr_wr,
  input wire logic [2:0] gpr_rd_sel,
  input wire logic gpr_rd_byte,
  input wire logic gpr_rd_high,
  output logic [15:0] gpr_rd_data,
  input wire crs_pkg::crs_seg_wr_s seg_wr,
  input wire crs_pkg::crs_alu_upd_s alu_upd,
  input wire crs_pkg::crs_flag_ctl_s flag_ctl,
  input wire logic instr_done,
  input wire logic ioff_adv,
  input wire logic [2:0] ioff_step,
  input wire logic ioff_load,
  input wire logic [15:0] ioff_data,
  input wire logic [1:0] addr_seg_sel,
  input wire logic [15:0] addr_offset,
  input wire logic int_req,
  output logic int_accept,
  output logic [15:0] instruction_offset,
  output logic [19:0] phys_addr,
  output logic [19:0] fetch_addr,
  output logic [15:0] processor_status_word,
  output logic [15:0] code_segment_base,
  output logic [15:0] data_segment_base,
  output logic [15:0] stack_segment_base,
  output logic [15:0] extra_segment_base,
  output logic string_step_up,
  output logic trace_trap,
  output logic [7:0] shift_count_byte,
  output logic [15:0] count_word,
  output logic [15:0] accumulator_word,
  output logic [15:0] data_word,
  output logic [15:0] io_port_addr
);

  crs_pkg::crs_state_s st;
  crs_pkg::crs_state_s next_st;

  logic wr_fire;
  logic rd_fire;
  logic [15:0] wmask;
  logic [15:0] sum_w;
  logic [16:0] wide_sum;
  logic [8:0] byte_sum;
  logic carry_out;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic [15:0] nib_carry;
  logic [15:0] flag_res;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // both write channels are taken together; a pending answer blocks the next
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
  assign rd_fire = s_axi_arvalid && !st.rvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  // upper byte lanes fall outside 16-bit registers and are dropped
  assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // ****************************************************************
  // flag arithmetic
  // ****************************************************************
  always_comb begin
    wide_sum = (alu_upd.kind == crs_pkg::CRS_ALU_SUB) ?
      ({1'b0, alu_upd.a} - {1'b0, alu_upd.b}) : ({1'b0, alu_upd.a} + {1'b0, alu_upd.b});
    byte_sum = (alu_upd.kind == crs_pkg::CRS_ALU_SUB) ?
      ({1'b0, alu_upd.a[7:0]} - {1'b0, alu_upd.b[7:0]}) :
      ({1'b0, alu_upd.a[7:0]} + {1'b0, alu_upd.b[7:0]});
    sum_w = wide_sum[15:0];
    flag_res = (alu_upd.kind == crs_pkg::CRS_ALU_LOGIC) ? alu_upd.res : sum_w;
    // borrow shows as the ninth or seventeenth bit of the difference too
    carry_out = alu_upd.word ? wide_sum[16] : byte_sum[8]; // RQ16
    msb_a = alu_upd.word ? alu_upd.a[15] : alu_upd.a[7];
    msb_b = alu_upd.word ? alu_upd.b[15] : alu_upd.b[7];
    msb_r = alu_upd.word ? flag_res[15] : flag_res[7];
    nib_carry = alu_upd.a ^ alu_upd.b ^ sum_w;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.trace_trap = 1'b0;

    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // software writes; the instruction offset has no address at all
    if (wr_fire) begin // RQ6
      next_st.bvalid = 1'b1;
      next_st.bresp = `CRS_RESP_OKAY;
      if (s_axi_awaddr[1:0] != 2'h0) begin
        next_st.bresp = `CRS_RESP_SLVERR;
      end else if (s_axi_awaddr < `CRS_OFF_CODE_SEG) begin
        next_st.gpr[s_axi_awaddr[4:2]] = (st.gpr[s_axi_awaddr[4:2]] & ~wmask) |
          (s_axi_wdata[15:0] & wmask); // RQ1
      end else if (s_axi_awaddr < `CRS_OFF_PSW) begin
        next_st.seg[s_axi_awaddr[3:2]] = (st.seg[s_axi_awaddr[3:2]] & ~wmask) |
          (s_axi_wdata[15:0] & wmask); // RQ2
      end else if (s_axi_awaddr == `CRS_OFF_PSW) begin
        next_st.psw = ((st.psw & ~wmask) | (s_axi_wdata[15:0] & wmask)) &
          `CRS_PSW_MASK; // RQ7
      end else begin
        next_st.bresp = `CRS_RESP_SLVERR;
      end
    end

    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `CRS_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0) begin
        next_st.rresp = `CRS_RESP_SLVERR;
      end else if (s_axi_araddr < `CRS_OFF_CODE_SEG) begin
        next_st.rdata = {16'h0000, st.gpr[s_axi_araddr[4:2]]};
      end else if (s_axi_araddr < `CRS_OFF_PSW) begin
        next_st.rdata = {16'h0000, st.seg[s_axi_araddr[3:2]]};
      end else if (s_axi_araddr == `CRS_OFF_PSW) begin
        next_st.rdata = {16'h0000, st.psw & `CRS_PSW_MASK}; // RQ7
      end else if (s_axi_araddr == `CRS_OFF_FETCH_ADDR) begin
        next_st.rdata = {12'h000, st.fetch_addr};
      end else begin
        next_st.rresp = `CRS_RESP_SLVERR;
      end
    end

    // datapath register writes come after the bus so they win
    if (gpr_wr.we) begin
      if (gpr_wr.byte_sel && gpr_wr.high) begin
        next_st.gpr[{1'b0, gpr_wr.sel[1:0]}][15:8] = gpr_wr.data[7:0]; // RQ1
      end else if (gpr_wr.byte_sel) begin
        next_st.gpr[{1'b0, gpr_wr.sel[1:0]}][7:0] = gpr_wr.data[7:0]; // RQ1
      end else begin
        next_st.gpr[gpr_wr.sel] = gpr_wr.data; // RQ1
      end
    end
    if (seg_wr.we) begin
      next_st.seg[seg_wr.sel] = seg_wr.data; // RQ2
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    if (alu_upd.valid) begin // RQ7
      next_st.psw[`CRS_BIT_SIGN] = msb_r; // RQ12
      next_st.psw[`CRS_BIT_ZERO] = alu_upd.word ? (flag_res == 16'h0000) :
        (flag_res[7:0] == 8'h00); // RQ13
      next_st.psw[`CRS_BIT_PARITY] = ~^flag_res[7:0]; // RQ15
      if (alu_upd.kind == crs_pkg::CRS_ALU_LOGIC) begin
        next_st.psw[`CRS_BIT_CARRY] = 1'b0;
        next_st.psw[`CRS_BIT_OVERFLOW] = 1'b0;
        next_st.psw[`CRS_BIT_AUX] = 1'b0;
      end else begin
        next_st.psw[`CRS_BIT_CARRY] = carry_out; // RQ16
        next_st.psw[`CRS_BIT_AUX] = nib_carry[4]; // RQ14
        if (alu_upd.kind == crs_pkg::CRS_ALU_SUB) begin
          next_st.psw[`CRS_BIT_OVERFLOW] = (msb_a != msb_b) && (msb_r != msb_a); // RQ8
        end else begin
          next_st.psw[`CRS_BIT_OVERFLOW] = (msb_a == msb_b) && (msb_r != msb_a); // RQ8
        end
      end
    end
    if (flag_ctl.set_dir) begin
      next_st.psw[`CRS_BIT_DIRECTION] = 1'b1; // RQ9
    end else if (flag_ctl.clr_dir) begin
      next_st.psw[`CRS_BIT_DIRECTION] = 1'b0; // RQ9
    end
    if (flag_ctl.set_int) begin
      next_st.psw[`CRS_BIT_INT_EN] = 1'b1; // RQ10
    end else if (flag_ctl.clr_int) begin
      next_st.psw[`CRS_BIT_INT_EN] = 1'b0; // RQ10
    end
    // a whole-word flag load replaces everything, reserved bits forced low
    if (flag_ctl.psw_load) begin
      next_st.psw = flag_ctl.psw_data & `CRS_PSW_MASK; // RQ7
    end

    // the trace bit is sampled before this cycle's update, so the loading
    // instruction itself traps only if trace was already set, and the one after it does
    if (instr_done && st.psw[`CRS_BIT_TRACE]) begin
      next_st.trace_trap = 1'b1; // RQ11
    end

    // ****************************************************************
    // instruction offset and addresses
    // ****************************************************************
    if (ioff_load) begin
      next_st.ioff = ioff_data; // RQ6
    end else if (ioff_adv) begin
      next_st.ioff = st.ioff + {13'h0000, ioff_step}; // RQ6
    end
    next_st.phys_addr = {st.seg[addr_seg_sel], 4'h0} + {4'h0, addr_offset}; // RQ17 RQ20
    // from the reset segment and offset this gives the first fetch address
    next_st.fetch_addr = {next_st.seg[0], 4'h0} + {4'h0, next_st.ioff}; // RQ5 RQ20
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.seg[0] <= `CRS_RST_CODE_SEG; // RQ3
      st.seg[1] <= `CRS_RST_SEG; // RQ4
      st.seg[2] <= `CRS_RST_SEG; // RQ4
      st.seg[3] <= `CRS_RST_SEG; // RQ4
      st.ioff <= `CRS_RST_IOFF; // RQ5
      st.psw <= `CRS_RST_PSW; // RQ7
      st.fetch_addr <= `CRS_RST_FETCH; // RQ5
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // datapath views
  // ****************************************************************
  always_comb begin
    if (gpr_rd_byte && gpr_rd_high) begin
      gpr_rd_data = {8'h00, st.gpr[{1'b0, gpr_rd_sel[1:0]}][15:8]}; // RQ1
    end else if (gpr_rd_byte) begin
      gpr_rd_data = {8'h00, st.gpr[{1'b0, gpr_rd_sel[1:0]}][7:0]}; // RQ1
    end else begin
      gpr_rd_data = st.gpr[gpr_rd_sel];
    end
  end

  assign int_accept = int_req && st.psw[`CRS_BIT_INT_EN]; // RQ10
  assign string_step_up = st.psw[`CRS_BIT_DIRECTION]; // RQ9
  assign trace_trap = st.trace_trap;
  assign instruction_offset = st.ioff;
  assign phys_addr = st.phys_addr;
  assign fetch_addr = st.fetch_addr;
  assign processor_status_word = st.psw;
  assign code_segment_base = st.seg[0];
  assign data_segment_base = st.seg[1];
  assign stack_segment_base = st.seg[2];
  assign extra_segment_base = st.seg[3];
  assign shift_count_byte = st.gpr[`CRS_IDX_COUNT][7:0]; // RQ18
  assign count_word = st.gpr[`CRS_IDX_COUNT]; // RQ18
  assign accumulator_word = st.gpr[`CRS_IDX_ACC]; // RQ19
  assign data_word = st.gpr[`CRS_IDX_DATA]; // RQ19
  assign io_port_addr = st.gpr[`CRS_IDX_DATA]; // RQ19

endmodule : crs_regs

// ---- sim/crs_regs_properties.sv ----
// Purpose: port-level temporal checks on the cpu register state block
// Assumes: bound to crs_regs, one clock domain, asynchronous active-low reset
// Notes: flag arithmetic is judged by the bench, not here
`timescale 1ns/1ps
module crs_regs_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic int_req,
  input wire logic int_accept,
  input wire logic instr_done,
  input wire logic trace_trap,
  input wire logic string_step_up,
  input wire logic [15:0] processor_status_word,
  input wire logic [15:0] code_segment_base,
  input wire logic [15:0] instruction_offset,
  input wire logic [19:0] fetch_addr
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  // trace bit must already be set before the finishing instruction
  sequence s_trace_due;
    processor_status_word[8] && instr_done;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_trace_trap: assert property (s_trace_due |=> trace_trap)
    else $error("trace trap missing");
  a_trace_quiet: assert property (!(processor_status_word[8] && instr_done) |=> !trace_trap)
    else $error("trace trap without cause");
  a_int_gate: assert property (int_accept == (int_req && processor_status_word[9]))
    else $error("interrupt accept not gated by enable bit");
  a_dir_view: assert property (string_step_up == processor_status_word[10])
    else $error("string step direction wrong");
  a_psw_reserved: assert property ((processor_status_word & 16'hF02A) == 16'h0000)
    else $error("reserved status bit set");
  a_fetch_form: assert property (fetch_addr == 20'({code_segment_base, 4'h0} + instruction_offset))
    else $error("fetch address not segment times 16 plus offset");
  a_reset_vals: assert property ($rose(rst_b) |-> code_segment_base == 16'hFFFF
    && instruction_offset == 16'h0000 && fetch_addr == 20'hFFFF0)
    else $error("reset start location wrong");
endmodule : crs_regs_properties

bind crs_regs crs_regs_properties crs_regs_properties_inst (
  .clk, .rst_b, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid,
  .int_req, .int_accept, .instr_done, .trace_trap, .string_step_up, .processor_status_word,
  .code_segment_base, .instruction_offset, .fetch_addr
);

// ---- sim/crs_dp_model.sv ----
// Purpose: execution datapath stand-in driving the state block's update ports
// Assumes: each update is a one-cycle pulse launched just after a rising edge
// Notes: issues legal updates only; an idle gap cycle follows each pulse
`timescale 1ns/1ps
module crs_dp_model (
  input wire logic clk,
  output crs_pkg::crs_gpr_wr_s gpr_wr,
  output crs_pkg::crs_seg_wr_s seg_wr,
  output crs_pkg::crs_alu_upd_s alu_upd,
  output crs_pkg::crs_flag_ctl_s flag_ctl,
  output logic ioff_adv,
  output logic ioff_load,
  output logic [2:0] ioff_step,
  output logic [15:0] ioff_data,
  output logic instr_done
);
  initial begin
    {gpr_wr, seg_wr, alu_upd, flag_ctl, ioff_adv, ioff_load, ioff_step, ioff_data} = '0;
    instr_done = 1'h0;
  end

  // io packs advance, load, step and load data
  task automatic op(input crs_pkg::crs_gpr_wr_s g, input crs_pkg::crs_seg_wr_s s,
                    input crs_pkg::crs_alu_upd_s a, input crs_pkg::crs_flag_ctl_s f,
                    input logic [20:0] io, input logic done);
    @(posedge clk);
    {gpr_wr, seg_wr, alu_upd, flag_ctl} <= {g, s, a, f};
    {ioff_adv, ioff_load, ioff_step, ioff_data, instr_done} <= {io, done};
    @(posedge clk);
    {gpr_wr, seg_wr, alu_upd, flag_ctl} <= '0;
    {ioff_adv, ioff_load, ioff_step, ioff_data, instr_done} <= '0;
  endtask : op
endmodule : crs_dp_model

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the cpu register state block
// Assumes: datapath stand-in crs_dp_model, register bus tasks below
// Notes: seeded random mix with a few hand corner cases
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_done;
  logic gpr_rd_byte, gpr_rd_high, ioff_adv, ioff_load, int_req, int_accept, string_step_up;
  logic trace_trap, wd, dir_m, ien_m;
  logic [7:0] s_axi_awaddr, s_axi_araddr, shift_count_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, addr_seg_sel, resp, k, s;
  logic [2:0] gpr_rd_sel, ioff_step, st;
  logic [15:0] gpr_rd_data, ioff_data, addr_offset, instruction_offset, processor_status_word;
  logic [15:0] code_segment_base, data_segment_base, stack_segment_base, extra_segment_base;
  logic [15:0] count_word, accumulator_word, data_word, io_port_addr, a, b, r, v, w, q;
  logic [19:0] phys_addr, fetch_addr;
  logic [15:0] seg_m [4];
  logic [50:0] hand [4];
  crs_pkg::crs_gpr_wr_s gpr_wr;
  crs_pkg::crs_seg_wr_s seg_wr;
  crs_pkg::crs_alu_upd_s alu_upd;
  crs_pkg::crs_flag_ctl_s flag_ctl;
  int err_total = 0;
  int n_compared = 0;

  crs_regs crs_regs_inst (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gpr_wr, .gpr_rd_sel, .gpr_rd_byte, .gpr_rd_high,
    .gpr_rd_data, .seg_wr, .alu_upd, .flag_ctl, .instr_done, .ioff_adv, .ioff_step, .ioff_load,
    .ioff_data, .addr_seg_sel, .addr_offset, .int_req, .int_accept, .instruction_offset,
    .phys_addr, .fetch_addr, .processor_status_word, .code_segment_base, .data_segment_base,
    .stack_segment_base, .extra_segment_base, .string_step_up, .trace_trap, .shift_count_byte,
    .count_word, .accumulator_word, .data_word, .io_port_addr);
  crs_dp_model crs_dp_model_inst (.clk, .gpr_wr, .seg_wr, .alu_upd, .flag_ctl, .ioff_adv,
    .ioff_load, .ioff_step, .ioff_data, .instr_done);

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [31:0] e,
                        input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    chk(nm, e, s_axi_rdata);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'h0;
  endtask : rd_chk

  // byte operations act on the low bytes only
  function automatic logic [15:0] exp_flags(input logic [1:0] kd, input logic wo,
                                            input logic [15:0] x, input logic [15:0] y,
                                            input logic [15:0] z);
    logic [16:0] sm;
    logic [15:0] m, f;
    int t;
    t = wo ? 15 : 7;
    if (!wo) {x, y, z} = {8'h0, x[7:0], 8'h0, y[7:0], 8'h0, z[7:0]};
    sm = kd == 2'h0 ? {1'h0, x} + {1'h0, y} : kd == 2'h1 ? {1'h0, x} - {1'h0, y} : {1'h0, z};
    m = x ^ y ^ sm[15:0];
    f = '0;
    f[7] = sm[t];
    f[6] = wo ? sm[15:0] == 16'h0 : sm[7:0] == 8'h0;
    f[2] = ~^sm[7:0];
    if (kd != 2'h2) begin
      f[11] = ((x[t] == y[t]) ^ (kd == 2'h1)) && (sm[t] != x[t]);
      f[4] = m[4];
      f[0] = sm[t+1];
    end
    return f;
  endfunction : exp_flags

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, addr_seg_sel, addr_offset, int_req} = '0;
    {gpr_rd_sel, gpr_rd_byte, gpr_rd_high} = '0;
    s_axi_wstrb = 4'hF;
    seg_m = '{16'hFFFF, 16'h0, 16'h0, 16'h0};
    hand = '{{2'h0, 1'h1, 16'h7FFF, 16'h0001, 16'h0}, {2'h1, 1'h1, 16'h0, 16'h0001, 16'h0},
             {2'h0, 1'h0, 16'h12FF, 16'h0001, 16'h0}, {2'h2, 1'h1, 16'h0, 16'h0, 16'h0}};
    void'($urandom(59));
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    chk("code seg", 32'hFFFF, code_segment_base);
    chk("data seg", 32'h0, data_segment_base);
    chk("stack seg", 32'h0, stack_segment_base);
    chk("extra seg", 32'h0, extra_segment_base);
    chk("offset", 32'h0, instruction_offset);
    chk("fetch", 32'hFFFF0, fetch_addr);
    chk("status", 32'h0, processor_status_word);
    rd_chk("bus code seg", 8'h20, 32'hFFFF, 2'h0);
    rd_chk("bus fetch", 8'h34, 32'hFFFF0, 2'h0);
    rd_chk("unmapped", 8'h40, 32'h0, 2'h2);
    rd_chk("unaligned", 8'h21, 32'h0, 2'h2);
    w = 16'($urandom);
    axi_wr(8'h28, {16'h0, w}, resp);
    chk("bus wr resp", 32'h0, {30'h0, resp});
    rd_chk("bus stack seg", 8'h28, {16'h0, w}, 2'h0);
    seg_m[2] = w;
    axi_wr(8'h30, 32'hFFFF, resp);
    rd_chk("status mask", 8'h30, 32'h0FD5, 2'h0);
    // trace must be clear before the flag load, else the load itself traps
    axi_wr(8'h30, 32'h0, resp);
    int_req <= 1'h1;
    crs_dp_model_inst.op('0, '0, '0, {5'h1, 16'h0100}, '0, 1'h1);
    #1;
    chk("no early trap", 32'h0, trace_trap);
    crs_dp_model_inst.op('0, '0, '0, '0, '0, 1'h1);
    #1;
    chk("trap", 32'h1, trace_trap);
    {dir_m, ien_m} = 2'h0;
    for (int i = 0; i < 16; i++) begin
      crs_dp_model_inst.op('0, '0, '0, {i[3:0], 17'h0}, '0, 1'h0);
      dir_m = i[3] | (dir_m & ~i[2]);
      ien_m = i[1] | (ien_m & ~i[0]);
      #1;
      chk("direction", {31'h0, dir_m}, {31'h0, string_step_up});
      chk("int accept", {31'h0, ien_m}, {31'h0, int_accept});
    end
    for (int i = 0; i < 64; i++) begin
      {k, wd, a, b, r} = i < 4 ? hand[i] : {2'($urandom % 3), 1'($urandom), 16'($urandom),
                                            16'($urandom), 16'($urandom)};
      crs_dp_model_inst.op('0, '0, {1'h1, k, wd, a, b, r}, '0, '0, 1'h0);
      #1;
      chk("flags", exp_flags(k, wd, a, b, r), processor_status_word & 16'h08D5);
    end
    {v, w, q} = {16'($urandom), 16'($urandom), 16'($urandom)};
    crs_dp_model_inst.op({4'h9, 2'h0, v}, '0, '0, '0, '0, 1'h0);
    crs_dp_model_inst.op({4'h9, 2'h3, w}, '0, '0, '0, '0, 1'h0);
    {gpr_rd_sel, gpr_rd_byte, gpr_rd_high} <= 5'h6;
    crs_dp_model_inst.op({4'h8, 2'h0, ~q}, '0, '0, '0, '0, 1'h0);
    crs_dp_model_inst.op({4'hA, 2'h0, q}, '0, '0, '0, '0, 1'h0);
    #1;
    chk("count word", {w[7:0], v[7:0]}, count_word);
    chk("shift count", v[7:0], shift_count_byte);
    chk("byte read", v[7:0], gpr_rd_data);
    chk("port addr", q, io_port_addr);
    chk("data word", q, data_word);
    chk("acc word", 16'(~q), accumulator_word);
    for (int i = 0; i < 20; i++) begin
      {s, v, w, st} = {2'($urandom), 16'($urandom), 16'($urandom), 3'($urandom)};
      seg_m[s] = v;
      crs_dp_model_inst.op('0, {1'h1, s, v}, '0, '0, {5'h8, w}, 1'h0);
      {addr_seg_sel, addr_offset} <= {s, w};
      crs_dp_model_inst.op('0, '0, '0, '0, {2'h2, st, 16'h0}, 1'h0);
      #1;
      chk("phys addr", 20'({seg_m[s], 4'h0} + w), phys_addr);
      chk("offset", 16'(w + st), instruction_offset);
      chk("fetch addr", 20'({seg_m[0], 4'h0} + 16'(w + st)), fetch_addr);
    end
    print_verdict();
  end
endmodule : tb_top
